// ===== pspb_pkg.sv
// Package for the parallel slave byte port: register map, fields, timing
package pspb_pkg;
  // Offsets are register indices; byte address = 4 * index
  localparam logic [7:0] IDX_PORT_D_DATA  = 8'h08;
  localparam logic [7:0] IDX_PORT_E_DATA  = 8'h09;
  localparam logic [7:0] IDX_INT_FLAGS    = 8'h0c;
  localparam logic [7:0] IDX_E_CTRL_STAT  = 8'h89;
  localparam logic [7:0] IDX_INT_ENABLES  = 8'h8c;
  localparam logic [7:0] IDX_ANALOG_CFG   = 8'h9f;
  localparam logic [7:0] IDX_PORT_D_DIR   = 8'h88;
  localparam logic [7:0] IDX_INT_STATUS   = 8'h90;

  // Field positions of the control/status, interrupt flag and interrupt enable registers
  localparam int BIT_IN_FULL  = 7;
  localparam int BIT_OUT_FULL = 6;
  localparam int BIT_IN_OVF   = 5;
  localparam int BIT_MODE   = 4;
  localparam int BIT_SPI_IF = 7;
  localparam int BIT_SPI_IE = 7;

  // Reset values
  localparam logic [2:0] RST_E_DIR    = 3'h7;
  localparam logic [7:0] RST_D_DIR    = 8'hff;
  localparam logic [7:0] RST_ZERO8    = 8'h00;
  localparam logic [3:0] RST_ANALOG   = 4'h0;
  // Analog select value at or above which the strobe pins are digital
  localparam logic [3:0] ANALOG_DIGITAL_MIN = 4'h6;

  // Four internal phases per instruction cycle
  localparam logic [1:0] PHASE_TWO  = 2'h1;
  localparam logic [1:0] PHASE_FOUR = 2'h3;

  // Strobe pin group as sampled
  typedef struct packed {
    logic sel_n;
    logic store_n;
    logic read_n;
  } pspb_strobe_s;

  // Completion tracker states
  typedef enum logic [1:0] {
    PSPB_IDLE  = 2'b00,
    PSPB_ARMED = 2'b01,
    PSPB_WAIT4 = 2'b10
  } pspb_done_e;
endpackage

// ===== pspb_port.sv
// Parallel slave byte port with APB register access
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pspb_port
  import pspb_pkg::*;
(
  input  wire logic                  pclk,            // 20 MHz system clock
  input  wire logic                  presetn,         // Asynchronous reset, active low
  input  wire logic                  psel,            // APB select
  input  wire logic                  penable,         // APB enable
  input  wire logic                  pwrite,          // APB direction
  input  wire logic [11:0]           paddr,           // APB byte address
  input  wire logic [31:0]           pwdata,          // APB write data
  output logic      [31:0]           prdata,          // APB read data
  output logic                       pready,          // APB ready
  output logic                       pslverr,         // APB error on unmapped address
  input  wire pspb_pkg::pspb_strobe_s strobe_in,      // Strobe pin levels
  output pspb_pkg::pspb_strobe_s     strobe_out,      // Strobe pin drive values
  output pspb_pkg::pspb_strobe_s     strobe_oe_n,     // Strobe pin enables, low drives
  input  wire logic [7:0]            data_in,         // Port D pin levels
  output logic      [7:0]            data_out,        // Port D drive values
  output logic      [7:0]            data_oe_n,       // Port D enables, low drives
  output logic                       slave_port_irq   // Interrupt request level
);
  import pspb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0]  out_latch_reg;
  logic [7:0]  in_latch_reg;
  logic [7:0]  port_d_dir_reg;
  logic [2:0]  e_out_reg;
  logic [2:0]  e_dir_reg;
  logic        mode_reg;
  logic        in_buf_full_reg;
  logic        out_buf_full_reg;
  logic        in_buf_overflow_reg;
  logic        int_flag_reg;
  logic        int_enable_reg;
  logic [3:0]  analog_reg;
  logic [1:0]  phase_reg;
  pspb_strobe_s sync1_reg;
  pspb_strobe_s sync2_reg;
  logic [7:0]  dsync1_reg;
  logic [7:0]  dsync2_reg;
  logic        wr_act_reg;
  logic        rd_act_reg;
  pspb_done_e  wdone_reg;
  pspb_done_e  rdone_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic        acc;
  logic        wr_en;
  logic        rd_en;
  logic [9:0]  idx;
  logic        mapped;
  assign acc    = psel && penable && pready;
  assign wr_en  = acc && pwrite && mapped;
  assign rd_en  = acc && !pwrite && mapped;
  assign idx    = paddr[11:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx[9:8] == 2'h0) &&
                  (idx[7:0] == IDX_PORT_D_DATA || idx[7:0] == IDX_PORT_E_DATA ||
                   idx[7:0] == IDX_INT_FLAGS   || idx[7:0] == IDX_E_CTRL_STAT ||
                   idx[7:0] == IDX_INT_ENABLES || idx[7:0] == IDX_ANALOG_CFG ||
                   idx[7:0] == IDX_PORT_D_DIR  || idx[7:0] == IDX_INT_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg  <= '1;
      sync2_reg  <= '1;
      dsync1_reg <= RST_ZERO8;
      dsync2_reg <= RST_ZERO8;
    end else begin
      sync1_reg  <= strobe_in;
      sync2_reg  <= sync1_reg;
      dsync1_reg <= data_in;
      dsync2_reg <= dsync1_reg;
    end
  end

  // Analog-selected pins read low; active strobes therefore need digital config
  logic        pins_digital;
  pspb_strobe_s strb;
  assign pins_digital = (analog_reg >= ANALOG_DIGITAL_MIN);
  assign strb         = pins_digital ? sync2_reg : '0;

  // Strobe qualification: select is active low and gates both strobes
  logic        wr_low;
  logic        rd_low;
  assign wr_low = mode_reg && !strb.sel_n && !strb.store_n;
  assign rd_low = mode_reg && !strb.sel_n && !strb.read_n;

  logic        wr_start;
  logic        wr_end;
  logic        rd_start;
  logic        rd_end;
  assign wr_start = wr_low && !wr_act_reg;
  assign wr_end   = !wr_low && wr_act_reg;
  assign rd_start = rd_low && !rd_act_reg;
  assign rd_end   = !rd_low && rd_act_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Four-phase internal clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Transaction activity tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_act_reg <= 1'b0;
      rd_act_reg <= 1'b0;
    end else begin
      wr_act_reg <= wr_low;
      rd_act_reg <= rd_low;
    end
  end

  // Input latch captures pins during the write strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_latch_reg <= RST_ZERO8;
    end else if (wr_low) begin
      in_latch_reg <= dsync2_reg;
    end
  end

  // Completion wait: next phase two, then phase four
  function automatic pspb_done_e done_step(input pspb_done_e st, input logic ending, input logic [1:0] ph);
    pspb_done_e nx;
    nx = st;
    case (st)
      PSPB_IDLE:  nx = ending ? PSPB_ARMED : PSPB_IDLE;
      PSPB_ARMED: nx = (ph == PHASE_TWO) ? PSPB_WAIT4 : PSPB_ARMED;
      PSPB_WAIT4: nx = (ph == PHASE_FOUR) ? PSPB_IDLE : PSPB_WAIT4;
      default:    nx = PSPB_IDLE;
    endcase
    return nx;
  endfunction

  logic wr_done;
  logic rd_done;
  assign wr_done = (wdone_reg == PSPB_WAIT4) && (phase_reg == PHASE_FOUR);
  assign rd_done = (rdone_reg == PSPB_WAIT4) && (phase_reg == PHASE_FOUR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdone_reg <= PSPB_IDLE;
      rdone_reg <= PSPB_IDLE;
    end else begin
      wdone_reg <= done_step(wdone_reg, wr_end, phase_reg);
      rdone_reg <= done_step(rdone_reg, rd_end, phase_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags
  logic rd_in_latch;
  assign rd_in_latch = rd_en && (idx[7:0] == IDX_PORT_D_DATA);

  // Input full: set at write completion, cleared by a data read, held clear outside slave mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_buf_full_reg <= 1'b0;
    end else if (!mode_reg) begin
      in_buf_full_reg <= 1'b0;
    end else if (wr_done) begin
      in_buf_full_reg <= 1'b1;
    end else if (rd_in_latch) begin
      in_buf_full_reg <= 1'b0;
    end
  end

  // Overflow: write start while byte unread, cleared only by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_buf_overflow_reg <= 1'b0;
    end else if (wr_start && in_buf_full_reg) begin
      in_buf_overflow_reg <= 1'b1;
    end else if (wr_en && idx[7:0] == IDX_E_CTRL_STAT && !pwdata[BIT_IN_OVF]) begin
      in_buf_overflow_reg <= 1'b0;
    end
  end

  // Output full: cleared at read start, set by processor write to the data latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_buf_full_reg <= 1'b0;
    end else if (!mode_reg) begin
      out_buf_full_reg <= 1'b0;
    end else if (rd_start) begin
      out_buf_full_reg <= 1'b0;
    end else if (wr_en && idx[7:0] == IDX_PORT_D_DATA) begin
      out_buf_full_reg <= 1'b1;
    end
  end

  // Interrupt flag latched at completions; set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_flag_reg <= 1'b0;
    end else if (wr_done || rd_done) begin
      int_flag_reg <= 1'b1;
    end else if (wr_en && idx[7:0] == IDX_INT_FLAGS) begin
      int_flag_reg <= pwdata[BIT_SPI_IF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_latch_reg  <= RST_ZERO8;
      port_d_dir_reg <= RST_D_DIR;
      e_out_reg      <= 3'h0;
      e_dir_reg      <= RST_E_DIR;
      mode_reg       <= 1'b0;
      int_enable_reg <= 1'b0;
      analog_reg     <= RST_ANALOG;
    end else if (wr_en) begin
      case (idx[7:0])
        IDX_PORT_D_DATA: out_latch_reg <= pwdata[7:0];
        IDX_PORT_E_DATA: e_out_reg <= pwdata[2:0];
        IDX_E_CTRL_STAT: begin
          mode_reg  <= pwdata[BIT_MODE];
          e_dir_reg <= pwdata[2:0];
        end
        IDX_INT_ENABLES: int_enable_reg <= pwdata[BIT_SPI_IE];
        IDX_ANALOG_CFG:  analog_reg <= pwdata[3:0];
        IDX_PORT_D_DIR:  port_d_dir_reg <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux and answer; zero wait states
  logic [7:0] ctrl_stat;
  logic [7:0] rmux;
  assign ctrl_stat = {in_buf_full_reg, out_buf_full_reg, in_buf_overflow_reg, mode_reg,
                      1'b0, e_dir_reg};
  always_comb begin
    rmux = RST_ZERO8;
    case (idx[7:0])
      IDX_PORT_D_DATA: rmux = mode_reg ? in_latch_reg : dsync2_reg;
      IDX_PORT_E_DATA: rmux = {5'h00, strb};
      IDX_INT_FLAGS:   rmux = {int_flag_reg, 7'h00};
      IDX_E_CTRL_STAT: rmux = ctrl_stat;
      IDX_INT_ENABLES: rmux = {int_enable_reg, 7'h00};
      IDX_ANALOG_CFG:  rmux = {4'h0, analog_reg};
      IDX_PORT_D_DIR:  rmux = port_d_dir_reg;
      IDX_INT_STATUS:  rmux = {int_flag_reg && int_enable_reg, 7'h00};
      default:         rmux = RST_ZERO8;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite && mapped) ? {24'h0, rmux} : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out       <= RST_ZERO8;
      data_oe_n      <= 8'hff;
      strobe_out     <= '0;
      strobe_oe_n    <= '1;
      slave_port_irq <= 1'b0;
    end else begin
      data_out       <= out_latch_reg;
      if (mode_reg) begin
        data_oe_n    <= rd_low ? 8'h00 : 8'hff;
      end else begin
        data_oe_n    <= port_d_dir_reg;
      end
      strobe_out     <= e_out_reg;
      strobe_oe_n    <= e_dir_reg;
      slave_port_irq <= int_flag_reg && int_enable_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_mode_reset;
    @(posedge pclk) $rose(presetn) |-> ctrl_stat == 8'h07;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("control/status not 07 after reset");

  property p_wr_done_phase;
    @(posedge pclk) disable iff (!presetn) wr_end |-> ##[2:9] (wr_done && phase_reg == PHASE_FOUR);
  endproperty
  a_wr_done_phase: assert property (p_wr_done_phase) else $error("write completion late");

  property p_ibf_set;
    @(posedge pclk) disable iff (!presetn) wr_done && mode_reg |=> in_buf_full_reg && int_flag_reg;
  endproperty
  a_ibf_set: assert property (p_ibf_set) else $error("full and flag not set together");

  property p_obf_clear;
    @(posedge pclk) disable iff (!presetn) rd_start |=> !out_buf_full_reg;
  endproperty
  a_obf_clear: assert property (p_obf_clear) else $error("output full not cleared");

  property p_rd_flag;
    @(posedge pclk) disable iff (!presetn) rd_end |-> ##[2:9] int_flag_reg;
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("read completion flag missing");

  property p_ovf;
    @(posedge pclk) disable iff (!presetn) wr_start && in_buf_full_reg |=> in_buf_overflow_reg;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");

  property p_offmode;
    @(posedge pclk) disable iff (!presetn) !mode_reg |=> !in_buf_full_reg && !out_buf_full_reg;
  endproperty
  a_offmode: assert property (p_offmode) else $error("flags not held clear");

  property p_drive;
    @(posedge pclk) disable iff (!presetn) mode_reg && rd_low |=> data_oe_n == 8'h00;
  endproperty
  a_drive: assert property (p_drive) else $error("data pins not driven");

  property p_irq;
    @(posedge pclk) disable iff (!presetn) slave_port_irq |-> $past(int_enable_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("request without enable");

  c_write: cover property (@(posedge pclk) disable iff (!presetn) wr_done);
  c_read:  cover property (@(posedge pclk) disable iff (!presetn) rd_done);
  c_ovf:   cover property (@(posedge pclk) disable iff (!presetn) $rose(in_buf_overflow_reg));
endmodule
`default_nettype wire

// ===== pspb_ext_master.sv
// Behavioural external byte-bus master that drives the slave port strobes and data
`timescale 1ns/1ps
`default_nettype none
module pspb_ext_master
  import pspb_pkg::*;
(
  input  wire logic              pclk,    // System clock
  input  wire logic [7:0]        pins,    // Resolved port D pin levels
  output var pspb_pkg::pspb_strobe_s strobe, // Strobe drive, idle high
  output var logic [7:0]         bus_val, // Data drive value
  output var logic               bus_en   // Data drive enable
);
  import pspb_pkg::*;
  initial begin
    strobe = '1;
    bus_val = 8'h00;
    bus_en = 1'b0;
  end
  // Byte write: data leads the strobes by a cycle and outlives them by one
  task automatic wr(input logic [7:0] d, input logic sel);
    @(posedge pclk);
    bus_val <= d;
    bus_en <= 1'b1;
    @(posedge pclk);
    strobe <= '{sel_n: ~sel, store_n: 1'b0, read_n: 1'b1};
    repeat (6) @(posedge pclk);
    strobe <= '1;
    @(posedge pclk);
    bus_en <= 1'b0;
  endtask
  // Byte read: strobes held low, pins sampled at the last edge before release
  task automatic rd(output logic [7:0] d);
    @(posedge pclk);
    strobe <= '{sel_n: 1'b0, store_n: 1'b1, read_n: 1'b0};
    repeat (6) @(posedge pclk);
    d = pins;
    @(posedge pclk);
    strobe <= '1;
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the parallel slave byte port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pspb_pkg::*;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         irq;
  pspb_strobe_s ext_strobe;
  pspb_strobe_s strobe_out;
  pspb_strobe_s strobe_oe_n;
  pspb_strobe_s strobe_pins;
  logic [7:0]   data_out;
  logic [7:0]   data_oe_n;
  logic [7:0]   bus_val;
  logic         bus_en;
  logic [7:0]   pins;
  logic [7:0]   last_pin = 8'h00;
  logic [31:0]  rd_s;
  logic         er_s;
  logic [7:0]   pin_s;
  int           mismatches = 0;
  int           cmp_count = 0;
  int           cycles = 0;

  always #25 pclk = ~pclk;
  // Pin resolution: undriven data lines show the inverse of their last level
  assign strobe_pins = pspb_strobe_s'((~strobe_oe_n & strobe_out) | (strobe_oe_n & ext_strobe));
  assign pins = (~data_oe_n & data_out) | (data_oe_n & (bus_en ? bus_val : ~last_pin));
  always @(posedge pclk) last_pin <= pins;

  pspb_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strobe_in(strobe_pins), .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n), .data_in(pins),
    .data_out(data_out), .data_oe_n(data_oe_n), .slave_port_irq(irq));
  pspb_ext_master i_ext (.pclk(pclk), .pins(pins), .strobe(ext_strobe), .bus_val(bus_val), .bus_en(bus_en));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparison and APB master tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v, rd_s, er_s);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, rd_s, er_s);
    chk(rd_s, {24'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(4);
    presetn <= 1'b1;
    rchk(IDX_E_CTRL_STAT, 8'h07);
    rchk(IDX_INT_FLAGS, 8'h00);
    rchk(IDX_INT_ENABLES, 8'h00);
    apb(1'b0, 8'h50, 8'h00, rd_s, er_s);
    chk({rd_s[31:1], er_s}, 32'h1);
    wreg(IDX_E_CTRL_STAT, 8'h08);
    rchk(IDX_E_CTRL_STAT, 8'h00);
    cyc(2);
    chk({29'h0, strobe_oe_n}, 32'h0);
    wreg(IDX_PORT_E_DATA, 8'h05);
    cyc(2);
    chk({29'h0, strobe_out}, 32'h5);
    wreg(IDX_E_CTRL_STAT, 8'h17);
    cyc(2);
    chk({29'h0, strobe_oe_n}, 32'h7);
    // Analog-selected strobes read low: a transfer opens but cannot end until the pins turn digital
    rchk(IDX_PORT_E_DATA, 8'h00);
    i_ext.wr(8'h11, 1'b1);
    cyc(12);
    rchk(IDX_E_CTRL_STAT, 8'h17);
    wreg(IDX_ANALOG_CFG, 8'h07);
    wreg(IDX_PORT_D_DIR, 8'h00);
    cyc(3);
    chk({24'h0, data_oe_n}, 32'hff);
    rchk(IDX_PORT_D_DIR, 8'h00);
    rchk(IDX_PORT_E_DATA, 8'h07);
    rchk(IDX_E_CTRL_STAT, 8'h97);
    rchk(IDX_PORT_D_DATA, 8'h00);
    wreg(IDX_INT_FLAGS, 8'h00);
    wreg(IDX_PORT_D_DATA, 8'h3c);
    rchk(IDX_E_CTRL_STAT, 8'h57);
    // External read with a register read overlapping the strobe
    fork
      i_ext.rd(pin_s);
      begin
        cyc(4);
        rchk(IDX_E_CTRL_STAT, 8'h17);
      end
    join
    chk({24'h0, pin_s}, 32'h3c);
    cyc(12);
    rchk(IDX_INT_FLAGS, 8'h80);
    chk({31'h0, irq}, 32'h0);
    wreg(IDX_INT_ENABLES, 8'h80);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    rchk(IDX_INT_STATUS, 8'h80);
    wreg(IDX_INT_FLAGS, 8'h00);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rchk(IDX_E_CTRL_STAT, 8'h17);
    // External write, then a second one over the unread byte
    i_ext.wr(8'ha5, 1'b1);
    cyc(12);
    rchk(IDX_E_CTRL_STAT, 8'h97);
    rchk(IDX_INT_FLAGS, 8'h80);
    wreg(IDX_E_CTRL_STAT, 8'h17);
    rchk(IDX_E_CTRL_STAT, 8'h97);
    i_ext.wr(8'h69, 1'b1);
    cyc(12);
    rchk(IDX_E_CTRL_STAT, 8'hb7);
    rchk(IDX_PORT_D_DATA, 8'h69);
    chk({24'h0, data_out}, 32'h3c);
    rchk(IDX_E_CTRL_STAT, 8'h37);
    wreg(IDX_E_CTRL_STAT, 8'h17);
    rchk(IDX_E_CTRL_STAT, 8'h17);
    i_ext.wr(8'h77, 1'b0);
    cyc(12);
    rchk(IDX_E_CTRL_STAT, 8'h17);
    // Leave slave mode with every status bit set
    wreg(IDX_PORT_D_DATA, 8'h12);
    i_ext.wr(8'h34, 1'b1);
    cyc(12);
    i_ext.wr(8'h56, 1'b1);
    cyc(12);
    rchk(IDX_E_CTRL_STAT, 8'hf7);
    wreg(IDX_E_CTRL_STAT, 8'h27);
    rchk(IDX_E_CTRL_STAT, 8'h27);
    i_ext.wr(8'h9a, 1'b1);
    cyc(12);
    rchk(IDX_E_CTRL_STAT, 8'h27);
    chk({24'h0, data_oe_n}, 32'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
